// >>> hw/lock_seq_regs.svh
// constants for the zero-delay lock sequencer
`ifndef LOCK_SEQ_REGS_SVH
`define LOCK_SEQ_REGS_SVH
// own register indexes on the command port
`define REG_CTRL 5'h00
`define REG_STATUS 5'h01
`define REG_VALID 5'h02
`define REG_PH2_WORD 5'h03
`define TABLE_SEL_BIT 4
// control bits
`define CTRL_START 0
`define CTRL_USE_LOCK 1
`define CTRL_GOE_QUIET 2
`define CTRL_SYNC_END 3
`define CTRL_LOCK_LOW 4
`define CTRL_BITS 5
// device word layout
`define WORD_BITS 32
`define WORD_MSB 31
`define ADDR_MSB 3
`define RESET_BIT 31
`define ZERO_DELAY_BIT 30
`define LOCK_MODE_TWO_BIT 29
`define R0_ADDR 4'h0
`define R15_ADDR 4'hf
`define TABLE_SIZE 16
// timing
`define CLOCK_NS 4
`define CAL_WAIT_NS 2000000
`define LINK_HALF 8'h04
`define SYNC_LOW_CYCLES 16'h0010
`define LAST_BIT 5'h1f
`endif

// >>> hw/lock_seq_pkg.sv
// types for the zero-delay lock sequencer
package lock_seq_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOAD = 6'h02,
    ST_SHIFT = 6'h04,
    ST_LATCH = 6'h08,
    ST_WAIT = 6'h10,
    ST_SYNC = 6'h20
  } seq_state_t;
endpackage : lock_seq_pkg

// >>> hw/zero_delay_lock_sequencer.sv
// host sequencer bringing a serially programmed clock conditioner into zero-delay lock
`timescale 1ns/10ps
`include "lock_seq_regs.svh"
module zero_delay_lock_sequencer #(
  parameter int CAL_WAIT_CYCLES = `CAL_WAIT_NS / `CLOCK_NS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // command port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // serial link to the device
  output logic o_link_clock,
  output logic o_link_data,
  output logic o_link_le,
  // control pins
  output logic o_global_output_enable_pin,
  output logic o_sync_n,
  input wire logic i_lock_indicator_pin
);
  lock_seq_pkg::seq_state_t state;
  logic rst_meta;
  logic rst_n;
  logic lock_meta;
  logic lock_sync;
  logic [`CTRL_BITS-1:1] cfg;
  logic [`TABLE_SIZE-1:0] valid;
  logic [`WORD_MSB:0] ph2_word;
  logic [`WORD_MSB:0] table_mem [`TABLE_SIZE];
  logic [`WORD_MSB:0] word;
  logic [4:0] idx;
  logic [4:0] bit_cnt;
  logic [1:0] item;
  logic phase;
  logic first;
  logic done;
  logic [7:0] div_cnt;
  logic tick;
  logic [31:0] wait_cnt;
  logic [15:0] sync_cnt;
  logic start_req;
  logic lock_active;
  logic [`WORD_MSB:0] load_word;

  // place address and force the register 0 control bits
  function automatic logic [`WORD_MSB:0] fix_word(input logic [`WORD_MSB:0] w,
                                                   input logic [`ADDR_MSB:0] a,
                                                   input logic zd);
    logic [`WORD_MSB:0] r;
    r = w;
    r[`ADDR_MSB:0] = a;
    if (a == `R0_ADDR) begin
      r[`RESET_BIT] = 1'b0;
      r[`LOCK_MODE_TWO_BIT] = 1'b1;
      r[`ZERO_DELAY_BIT] = zd;
    end
    return r;
  endfunction : fix_word

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // lock pin arrives from outside; two flops before use
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= i_lock_indicator_pin;
      lock_sync <= lock_meta;
    end
  end

  // selector 3 active high, 4 active low
  assign lock_active = lock_sync ^ cfg[`CTRL_LOCK_LOW];
  assign start_req = i_wr && (i_addr == `REG_CTRL) && i_wdata[`CTRL_START]
                     && (state == lock_seq_pkg::ST_IDLE);
  // phase one table word, shared by the word register and its first data bit
  assign load_word = fix_word(table_mem[idx[`ADDR_MSB:0]], idx[`ADDR_MSB:0], 1'b0);

  // configuration written by software; table holds words chosen by software
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      valid <= '0;
      ph2_word <= '0;
    end else if (i_wr && state == lock_seq_pkg::ST_IDLE) begin
      if (i_addr == `REG_CTRL) cfg <= i_wdata[`CTRL_BITS-1:1];
      if (i_addr == `REG_VALID) valid <= i_wdata[`TABLE_SIZE-1:0];
      if (i_addr == `REG_PH2_WORD) ph2_word <= i_wdata;
    end
  end

  // storage has no reset; words are defined by software before start
  always_ff @(posedge i_clock) begin
    if (i_wr && i_addr[`TABLE_SEL_BIT] && state == lock_seq_pkg::ST_IDLE) begin
      table_mem[i_addr[`ADDR_MSB:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr[`TABLE_SEL_BIT]) begin
        o_rdata <= table_mem[i_addr[`ADDR_MSB:0]];
      end else begin
        unique case (i_addr)
          `REG_CTRL: o_rdata <= {27'h0000000, cfg, 1'b0};
          `REG_STATUS: o_rdata <= {28'h0000000, lock_active, phase, done,
                                   state != lock_seq_pkg::ST_IDLE};
          `REG_VALID: o_rdata <= {16'h0000, valid};
          `REG_PH2_WORD: o_rdata <= ph2_word;
          default: o_rdata <= '0;
        endcase
      end
    end else begin
      o_rdata <= '0;
    end
  end

  // link clock divider, runs only while a word is on the wire
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (state != lock_seq_pkg::ST_SHIFT && state != lock_seq_pkg::ST_LATCH) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == `LINK_HALF - 8'h01) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= lock_seq_pkg::ST_IDLE;
      word <= '0;
      idx <= '0;
      bit_cnt <= '0;
      item <= '0;
      phase <= 1'b0;
      first <= 1'b0;
      done <= 1'b0;
      wait_cnt <= '0;
      sync_cnt <= '0;
      o_link_clock <= 1'b0;
      o_link_data <= 1'b0;
      o_link_le <= 1'b0;
      o_global_output_enable_pin <= 1'b0;
      o_sync_n <= 1'b1;
    end else begin
      unique case (state)
        lock_seq_pkg::ST_IDLE: begin
          if (start_req) begin
            phase <= 1'b0;
            first <= 1'b1;
            idx <= '0;
            done <= 1'b0;
            o_sync_n <= 1'b1;
            // asynchronous at the device, so only moved between words
            o_global_output_enable_pin <= ~i_wdata[`CTRL_GOE_QUIET];
            state <= lock_seq_pkg::ST_LOAD;
          end
        end
        lock_seq_pkg::ST_LOAD: begin
          o_link_clock <= 1'b0;
          o_link_le <= 1'b0;
          bit_cnt <= '0;
          if (!phase) begin
            if (first) begin
              first <= 1'b0;
              word <= {1'b1, 27'h0000000, `R0_ADDR};
              o_link_data <= 1'b1;
              state <= lock_seq_pkg::ST_SHIFT;
            end else if (idx[4]) begin
              wait_cnt <= '0;
              state <= lock_seq_pkg::ST_WAIT;
            end else begin
              // ascending index keeps register 15 last
              idx <= idx + 5'h01;
              if (valid[idx[`ADDR_MSB:0]]) begin
                word <= load_word;
                o_link_data <= load_word[`WORD_MSB];
                state <= lock_seq_pkg::ST_SHIFT;
              end
            end
          end else begin
            item <= item + 2'h1;
            if (item == 2'h0) begin
              word <= fix_word(table_mem[`R0_ADDR], `R0_ADDR, 1'b1);
              o_link_data <= 1'b0;
              state <= lock_seq_pkg::ST_SHIFT;
            end else if (item == 2'h1) begin
              word <= fix_word(ph2_word, `R15_ADDR, 1'b0);
              o_link_data <= ph2_word[`WORD_MSB];
              state <= lock_seq_pkg::ST_SHIFT;
            end else if (cfg[`CTRL_SYNC_END]) begin
              o_sync_n <= 1'b0;
              sync_cnt <= '0;
              state <= lock_seq_pkg::ST_SYNC;
            end else begin
              done <= 1'b1;
              state <= lock_seq_pkg::ST_IDLE;
            end
          end
        end
        lock_seq_pkg::ST_SHIFT: begin
          if (tick) begin
            if (!o_link_clock) begin
              o_link_clock <= 1'b1;
            end else begin
              o_link_clock <= 1'b0;
              if (bit_cnt == `LAST_BIT) begin
                o_link_le <= 1'b1;
                state <= lock_seq_pkg::ST_LATCH;
              end else begin
                bit_cnt <= bit_cnt + 5'h01;
                word <= {word[`WORD_MSB-1:0], 1'b0};
                o_link_data <= word[`WORD_MSB-1];
              end
            end
          end
        end
        lock_seq_pkg::ST_LATCH: begin
          if (tick) begin
            o_link_le <= 1'b0;
            state <= lock_seq_pkg::ST_LOAD;
          end
        end
        lock_seq_pkg::ST_WAIT: begin
          wait_cnt <= wait_cnt + 32'h1;
          if (cfg[`CTRL_USE_LOCK] ? lock_active
              : (wait_cnt >= 32'(CAL_WAIT_CYCLES - 1))) begin
            phase <= 1'b1;
            item <= '0;
            o_global_output_enable_pin <= 1'b1;
            state <= lock_seq_pkg::ST_LOAD;
          end
        end
        lock_seq_pkg::ST_SYNC: begin
          sync_cnt <= sync_cnt + 16'h0001;
          if (sync_cnt == `SYNC_LOW_CYCLES - 16'h0001) begin
            o_sync_n <= 1'b1;
            done <= 1'b1;
            state <= lock_seq_pkg::ST_IDLE;
          end
        end
        default: state <= lock_seq_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  AST_LE_ONLY_LATCH: assert property (
    o_link_le |-> state == lock_seq_pkg::ST_LATCH)
    else $error("latch enable outside latch state");
  AST_CLOCK_IDLE_LOW: assert property (
    state == lock_seq_pkg::ST_IDLE |-> !o_link_clock && !o_link_le)
    else $error("link active while idle");
  AST_DATA_STABLE_HIGH: assert property (
    $rose(o_link_clock) |=> $stable(o_link_data) [*3])
    else $error("data moved while link clock high");
  AST_FIRST_RESET_WORD: assert property (
    start_req |=> ##1 (state == lock_seq_pkg::ST_SHIFT && word[`RESET_BIT]
                       && word[`ADDR_MSB:0] == `R0_ADDR))
    else $error("first write is not a reset write");
  AST_LATER_R0_CLEAR: assert property (
    $past(state == lock_seq_pkg::ST_LOAD) && state == lock_seq_pkg::ST_SHIFT
    && !$past(first) && word[`ADDR_MSB:0] == `R0_ADDR |-> !word[`RESET_BIT]
    && word[`LOCK_MODE_TWO_BIT] && word[`ZERO_DELAY_BIT] == phase)
    else $error("register 0 rewrite carries wrong control bits");
  AST_GOE_QUIET_PH1: assert property (
    cfg[`CTRL_GOE_QUIET] && !phase && state != lock_seq_pkg::ST_IDLE
    |-> !o_global_output_enable_pin)
    else $error("output enable pin high in quiet first phase");
  AST_GOE_PH2: assert property (
    phase && state != lock_seq_pkg::ST_IDLE |-> o_global_output_enable_pin)
    else $error("output enable pin low in second phase");
  AST_PH2_AFTER_LOCK: assert property (
    $rose(phase) |-> $past(cfg[`CTRL_USE_LOCK] ? lock_active
                           : wait_cnt >= 32'(CAL_WAIT_CYCLES - 1)))
    else $error("second phase began before calibration done");
  AST_SYNC_PULSE_LEN: assert property (
    $fell(o_sync_n) |-> !o_sync_n [*8] ##1 !o_sync_n [*8] ##1 o_sync_n)
    else $error("sync pulse has wrong length");
  AST_SYNC_ONLY_PULSE: assert property (
    state != lock_seq_pkg::ST_SYNC |-> o_sync_n)
    else $error("sync pin low outside the end pulse");
  AST_CLOCK_HIGH_LEN: assert property (
    $rose(o_link_clock) |-> o_link_clock [*4] ##1 !o_link_clock)
    else $error("link clock high phase has wrong length");
  AST_LE_PULSE_LEN: assert property (
    $rose(o_link_le) |-> o_link_le [*4] ##1 !o_link_le)
    else $error("latch enable pulse has wrong length");
  AST_FIRST_BIT_MSB: assert property (
    $past(state == lock_seq_pkg::ST_LOAD) && state == lock_seq_pkg::ST_SHIFT
    |-> o_link_data == word[`WORD_MSB])
    else $error("first data bit is not the word msb");
  AST_PH2_LAST_R15: assert property (
    $past(state == lock_seq_pkg::ST_LOAD) && state == lock_seq_pkg::ST_SHIFT && phase
    && $past(item) == 2'h1 |-> word[`ADDR_MSB:0] == `R15_ADDR)
    else $error("second phase two word is not register 15");

  COV_PHASE_TWO: cover property ($rose(phase));
  COV_SYNC_PULSE: cover property ($fell(o_sync_n));
  COV_DONE: cover property ($rose(done));
  COV_LOCK_WAIT: cover property (state == lock_seq_pkg::ST_WAIT && lock_active);
endmodule : zero_delay_lock_sequencer

// >>> dv/lock_device_model.sv
// behavioural model of the serially programmed clock conditioner
`timescale 1ns/10ps
module lock_device_model #(
  parameter int CAL_CYCLES = 40
) (
  // clock for settling delays
  input wire logic i_clock,
  // serial link
  input wire logic i_link_clock,
  input wire logic i_link_data,
  input wire logic i_link_le,
  // pins
  input wire logic i_global_output_enable_pin,
  input wire logic i_sync_n,
  input wire logic i_active_low,
  output logic o_lock_indicator_pin
);
  logic [31:0] shift = 32'h0;
  logic [31:0] log_word [0:31];
  logic [1:0] log_pins [0:31];
  int log_t [0:31];
  int n = 0;
  int cyc = 0;
  int t_cal = 0;
  bit cal_run = 1'b0;
  bit lock_on = 1'b0;
  always @(posedge i_clock) begin
    cyc++;
    if (cal_run && cyc - t_cal >= CAL_CYCLES) lock_on = 1'b1;
  end
  always @(posedge i_link_clock) if (!i_link_le) shift = {shift[30:0], i_link_data};
  always @(posedge i_link_le) begin
    if (n < 32) begin
      log_word[n] = shift;
      log_pins[n] = {i_global_output_enable_pin, i_sync_n};
      log_t[n] = cyc;
      n++;
    end
    // register 0 drops the indication: reset or back to lock detect
    if (shift[3:0] == 4'h0) lock_on = 1'b0;
    if (shift[3:0] == 4'h0 && shift[31]) cal_run = 1'b0;
    if (shift[3:0] == 4'hf) begin
      cal_run = 1'b1;
      t_cal = cyc;
      lock_on = 1'b0;
    end
  end
  assign o_lock_indicator_pin = lock_on ^ i_active_low;
endmodule : lock_device_model

// >>> dv/tb_top.sv
// self-checking testbench for the zero-delay lock sequencer
`timescale 1ns/10ps
`include "lock_seq_regs.svh"
module tb_top;
  localparam int CALW = 200;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic act_low = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rd_val;
  logic lclk, ldat, lle, global_output_enable_pin, sync_n, lock;
  int errors = 0;
  int checks = 0;
  int sync_low = 0;
  zero_delay_lock_sequencer #(.CAL_WAIT_CYCLES(CALW)) DUT (.i_clock(clk), .i_resetn(rstn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_link_clock(lclk), .o_link_data(ldat), .o_link_le(lle),
    .o_global_output_enable_pin(global_output_enable_pin), .o_sync_n(sync_n), .i_lock_indicator_pin(lock));
  lock_device_model dm (.i_clock(clk), .i_link_clock(lclk), .i_link_data(ldat),
    .i_link_le(lle), .i_global_output_enable_pin(global_output_enable_pin), .i_sync_n(sync_n),
    .i_active_low(act_low), .o_lock_indicator_pin(lock));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (sync_n === 1'b0) sync_low++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask : rd_reg
  function automatic logic [31:0] tbl(input int k);
    return 32'hc3a50000 | (32'(k) << 8);
  endfunction : tbl
  // register 0 gets reset cleared, lock mode two set, zero delay as asked
  function automatic logic [31:0] exp_word(input int k, input logic zd);
    if (k == 0) return (tbl(0) & 32'h1ffffff0) | 32'h20000000 | {1'b0, zd, 30'h0};
    return tbl(k) | 32'(k);
  endfunction : exp_word
  task automatic run(input logic [4:0] ctrl, input logic [15:0] mask);
    int n1;
    int gap;
    dm.n = 0;
    sync_low = 0;
    act_low <= ctrl[`CTRL_LOCK_LOW];
    wr_reg(`REG_VALID, {16'h0, mask});
    for (int k = 0; k < 16; k++) wr_reg(5'(16 + k), tbl(k));
    wr_reg(`REG_PH2_WORD, 32'h12345673);
    wr_reg(`REG_CTRL, {27'h0, ctrl} | 32'h1);
    repeat (4) @(posedge clk);
    wr_reg(`REG_VALID, 32'hffff);
    rd_val = 32'h1;
    for (int w = 0; w < 5000 && rd_val[0] !== 1'b0; w++) rd_reg(`REG_STATUS);
    chk(rd_val & 32'h7, 32'h6);
    rd_reg(`REG_VALID);
    chk(rd_val, {16'h0, mask});
    rd_reg(`REG_PH2_WORD);
    chk(rd_val, 32'h12345673);
    rd_reg(`REG_CTRL);
    chk(rd_val, {27'h0, ctrl[4:1], 1'b0});
    rd_reg(5'h15);
    chk(rd_val, tbl(5));
    chk(dm.log_word[0], 32'h80000000);
    chk(32'(dm.log_pins[0]), {30'h0, ~ctrl[`CTRL_GOE_QUIET], 1'b1});
    n1 = 1;
    for (int k = 0; k < 16; k++) begin
      if (mask[k]) begin
        chk(dm.log_word[n1], exp_word(k, 1'b0));
        chk(32'(dm.log_pins[n1]), {30'h0, ~ctrl[`CTRL_GOE_QUIET], 1'b1});
        n1++;
      end
    end
    chk(dm.log_word[n1], exp_word(0, 1'b1));
    chk(dm.log_word[n1 + 1], 32'h1234567f);
    chk(32'(dm.n), 32'(n1 + 2));
    chk(32'(dm.log_pins[n1]), 32'h3);
    chk(32'(dm.log_pins[n1 + 1]), 32'h3);
    gap = dm.log_t[n1] - dm.log_t[n1 - 1];
    // a word takes at least 256 cycles, so a timed wait ends later than this
    chk({31'h0, gap < CALW + 256}, {31'h0, ctrl[`CTRL_USE_LOCK]});
    chk(32'(sync_low), ctrl[`CTRL_SYNC_END] ? 32'h10 : 32'h0);
    // lock shows some cycles after the last register 15 write
    repeat (60) @(posedge clk);
    rd_reg(`REG_STATUS);
    chk(rd_val, 32'he);
  endtask : run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({28'h0, global_output_enable_pin, sync_n, lle, lclk}, 32'h4);
    rd_reg(5'h05);
    chk(rd_val, 32'h0);
    rd_reg(`REG_STATUS);
    chk(rd_val, 32'h0);
    run(5'b01110, 16'h8061);
    run(5'b10010, 16'hc001);
    run(5'b00000, 16'h8001);
    tally_and_finish();
  end
endmodule : tb_top
